// *** src/tcs_pkg.sv ***
// constants and types for the timer channel irq / status / pin control block
package tcs_pkg;
   // register byte offsets inside one channel window, the channel stride and the control register offset
   localparam logic [6:0] OFF_IO_CTRL  = 7'h00;
   localparam logic [6:0] OFF_IRQ_EN   = 7'h04;
   localparam logic [6:0] OFF_STATUS   = 7'h08;
   localparam logic [6:0] OFF_COUNTER  = 7'h0c;
   localparam logic [6:0] OFF_GEN_A    = 7'h10;
   localparam logic [6:0] OFF_CLEAR    = 7'h14;
   localparam logic [6:0] CH_STRIDE    = 7'h20;
   localparam logic [6:0] OFF_CONTROL  = 7'h40;
   // bit positions shared by enable, status and clear registers
   localparam int BIT_GEN_A  = 0;
   localparam int BIT_GEN_B  = 1;
   localparam int BIT_OVF    = 4;
   localparam int BIT_UNF    = 5;
   localparam int BIT_FIXED  = 6;
   localparam int BIT_TOP    = 7;
   // internal flag vector order
   localparam int FLG_A   = 0;
   localparam int FLG_B   = 1;
   localparam int FLG_OVF = 2;
   localparam int FLG_UNF = 3;
   // reset values and counter limits
   localparam logic [3:0]  RST_IO      = 4'h0;
   localparam logic [15:0] RST_COUNTER = 16'h0000;
   localparam logic [15:0] RST_GEN_A   = 16'hffff;
   localparam logic        RST_DIR     = 1'b1;
   localparam logic [15:0] CNT_TOP     = 16'hffff;
   localparam logic [15:0] CNT_BOTTOM  = 16'h0000;
   // conversion trigger bit exists in this unit
   localparam logic        CONV_TRIG_PRESENT = 1'b1;
   // ahb-lite
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0]  HSIZE_WORD    = 3'h2;
   localparam logic        HRESP_OKAY    = 1'b0;

   typedef struct packed {
      logic             pin_prev;
      logic             level;
      logic             oe;
      logic             cap;
      logic             match;
   } tcs_pin_state_t;

   typedef struct packed {
      logic [6:0]       addr;
      logic             wr_pend;
      logic             rd_pend;
      logic             ready;
      logic             resp;
      logic [31:0]      rdata;
      logic [1:0]       start;
      logic [1:0][3:0]  io;
      logic [1:0]       io_wr;
      logic [1:0]       conv_trigger_en;
      logic [1:0][3:0]  en;
      logic [1:0][3:0]  flag;
      logic [1:0][3:0]  armed;
      logic [1:0]       dir;
      logic [1:0][15:0] cnt;
      logic [1:0]       step;
      logic [1:0][15:0] greg;
      logic [1:0][3:0]  irq;
      logic             any_irq;
      logic [1:0]       conv;
   } tcs_core_t;
endpackage

// *** src/tcs_pin_if.sv ***
// link between the register core and one channel's pin logic
`timescale 1ns/1ps
`default_nettype none
interface tcs_pin_if;
   logic [3:0]  io_code;
   logic        io_wr;
   logic [15:0] cnt;
   logic        cnt_step;
   logic [15:0] greg;
   logic        pin_in;
   logic        cascade_evt;
   logic        pin_out;
   logic        pin_oe;
   logic        capture;
   logic        match;
   modport core (output io_code, io_wr, cnt, cnt_step, greg, pin_in, cascade_evt,
                 input pin_out, pin_oe, capture, match);
   modport pin  (input io_code, io_wr, cnt, cnt_step, greg, pin_in, cascade_evt,
                 output pin_out, pin_oe, capture, match);
endinterface
`default_nettype wire

// *** src/tcs_pin_ch.sv ***
// compare output and capture edge logic of one channel's a pin
`timescale 1ns/1ps
`default_nettype none
module tcs_pin_ch #(
   parameter bit HAS_CASCADE = 1'b0
) (
   input  wire logic     clk_i,
   input  wire logic     resetn_i,
   tcs_pin_if.pin        p
);
   tcs_pkg::tcs_pin_state_t r;
   tcs_pkg::tcs_pin_state_t n;

   // next state: code bit 3 picks capture, else compare output
   always_comb begin
      n = r;
      n.cap = 1'b0;
      n.match = 1'b0;
      n.pin_prev = p.pin_in;
      if (!p.io_code[3]) begin
         n.oe = (p.io_code[1:0] != 2'b00);
         if (p.cnt_step && (p.cnt == p.greg)) begin
            n.match = 1'b1;
         end
         // a code write reloads the initial level before any match
         if (p.io_wr) begin
            n.level = p.io_code[2];
         end else if (n.match) begin
            case (p.io_code[1:0])
               2'b01: n.level = 1'b0;
               2'b10: n.level = 1'b1;
               2'b11: n.level = ~r.level;
               default: n.level = r.level;
            endcase
         end
      end else begin
         n.oe = 1'b0;
         if (HAS_CASCADE && p.io_code[2]) begin
            n.cap = p.cascade_evt;
         end else begin
            // bit 2 is ignored where there is no cascade source
            case (p.io_code[1:0])
               2'b00: n.cap = p.pin_in & ~r.pin_prev;
               2'b01: n.cap = ~p.pin_in & r.pin_prev;
               default: n.cap = p.pin_in ^ r.pin_prev;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign p.pin_out = r.level;
   assign p.pin_oe  = r.oe;
   assign p.capture = r.cap;
   assign p.match   = r.match;
endmodule
`default_nettype wire

// *** src/tcs_core.sv ***
// register file, counters, flags and interrupt lines for timer channels 4 and 5
//
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tcs_core (
   input  wire logic        CLK_SYS_I,
   input  wire logic        RESETN_I,
   input  wire logic        HSEL_I,
   input  wire logic [31:0] HADDR_I,
   input  wire logic [1:0]  HTRANS_I,
   input  wire logic        HWRITE_I,
   input  wire logic [2:0]  HSIZE_I,
   input  wire logic [31:0] HWDATA_I,
   input  wire logic        HREADY_I,
   output logic      [31:0] HRDATA_O,
   output logic             HREADYOUT_O,
   output logic             HRESP_O,
   input  wire logic [1:0]  COUNT_TICK_I,
   input  wire logic [1:0]  COUNT_DOWN_I,
   input  wire logic [1:0]  GEN_B_EVENT_I,
   input  wire logic        CH3_A_EVENT_I,
   input  wire logic [1:0]  A_PIN_I,
   output logic      [1:0]  A_PIN_O,
   output logic      [1:0]  A_PIN_OE_O,
   output logic      [1:0]  IRQ_GEN_A_O,
   output logic      [1:0]  IRQ_GEN_B_O,
   output logic      [1:0]  IRQ_OVF_O,
   output logic      [1:0]  IRQ_UNF_O,
   output logic             IRQ_O,
   output logic      [1:0]  CONV_REQ_O
);
   tcs_pkg::tcs_core_t r;
   tcs_pkg::tcs_core_t n;
   logic [1:0] pin_cap;
   logic [1:0] pin_match;
   logic [1:0] pin_lvl;
   logic [1:0] pin_oe;

   // one pin block per channel; only channel 4 has the cascade source
   for (genvar g = 0; g < 2; g++) begin : g_pin
      tcs_pin_if pif ();
      assign pif.io_code     = r.io[g];
      assign pif.io_wr       = r.io_wr[g];
      assign pif.cnt         = r.cnt[g];
      assign pif.cnt_step    = r.step[g];
      assign pif.greg        = r.greg[g];
      assign pif.pin_in      = A_PIN_I[g];
      assign pif.cascade_evt = (g == 0) ? CH3_A_EVENT_I : 1'b0;
      assign pin_cap[g]      = pif.capture;
      assign pin_match[g]    = pif.match;
      assign pin_lvl[g]      = pif.pin_out;
      assign pin_oe[g]       = pif.pin_oe;
      tcs_pin_ch #(
         .HAS_CASCADE (g == 0)
      ) u_pin (
         .clk_i    (CLK_SYS_I),
         .resetn_i (RESETN_I),
         .p        (pif.pin)
      );
   end

   // enable register image; bits 3 and 2 have no c/d registers here
   function automatic logic [7:0] en_byte(input logic conv_trigger_en, input logic [3:0] en);
      logic [7:0] v;
      v = 8'h00;
      v[tcs_pkg::BIT_TOP]   = conv_trigger_en & tcs_pkg::CONV_TRIG_PRESENT;
      v[tcs_pkg::BIT_FIXED] = 1'b1;
      v[tcs_pkg::BIT_UNF]   = en[tcs_pkg::FLG_UNF];
      v[tcs_pkg::BIT_OVF]   = en[tcs_pkg::FLG_OVF];
      v[tcs_pkg::BIT_GEN_B] = en[tcs_pkg::FLG_B];
      v[tcs_pkg::BIT_GEN_A] = en[tcs_pkg::FLG_A];
      return v;
   endfunction

   // status register image
   function automatic logic [7:0] st_byte(input logic dir, input logic [3:0] f);
      logic [7:0] v;
      v = 8'h00;
      v[tcs_pkg::BIT_TOP]   = dir;
      v[tcs_pkg::BIT_FIXED] = 1'b1;
      v[tcs_pkg::BIT_UNF]   = f[tcs_pkg::FLG_UNF];
      v[tcs_pkg::BIT_OVF]   = f[tcs_pkg::FLG_OVF];
      v[tcs_pkg::BIT_GEN_B] = f[tcs_pkg::FLG_B];
      v[tcs_pkg::BIT_GEN_A] = f[tcs_pkg::FLG_A];
      return v;
   endfunction

   // byte layout back to the internal flag order
   function automatic logic [3:0] to_flags(input logic [7:0] b);
      logic [3:0] v;
      v = 4'h0;
      v[tcs_pkg::FLG_UNF] = b[tcs_pkg::BIT_UNF];
      v[tcs_pkg::FLG_OVF] = b[tcs_pkg::BIT_OVF];
      v[tcs_pkg::FLG_B]   = b[tcs_pkg::BIT_GEN_B];
      v[tcs_pkg::FLG_A]   = b[tcs_pkg::BIT_GEN_A];
      return v;
   endfunction

   // whole next state of the core
   always_comb begin
      logic [1:0][3:0] clr_req;
      logic [1:0][3:0] arm;
      logic [1:0][3:0] setv;
      logic [1:0]      wr_cnt;
      logic [1:0]      wr_greg;
      logic [31:0]     rd;
      logic [6:0]      off;
      logic            ch;
      logic            in_ch;
      logic            accept;
      clr_req = '0;
      arm     = '0;
      setv    = '0;
      wr_cnt  = '0;
      wr_greg = '0;
      rd      = 32'h0000_0000;
      off     = r.addr & (tcs_pkg::CH_STRIDE - 7'h01);
      ch      = r.addr[5];
      in_ch   = (r.addr < tcs_pkg::OFF_CONTROL);
      accept  = HSEL_I && HREADY_I && (HTRANS_I == tcs_pkg::HTRANS_NONSEQ)
                && (HSIZE_I == tcs_pkg::HSIZE_WORD);
      n = r;
      n.io_wr = '0;
      n.conv  = '0;
      n.step  = '0;

      // data phase of a write: applied at the end of its one cycle
      if (r.wr_pend) begin
         if (in_ch && off == tcs_pkg::OFF_IO_CTRL) begin
            n.io[ch]    = HWDATA_I[3:0];
            n.io_wr[ch] = 1'b1;
         end else if (in_ch && off == tcs_pkg::OFF_IRQ_EN) begin
            n.conv_trigger_en[ch] = HWDATA_I[tcs_pkg::BIT_TOP] & tcs_pkg::CONV_TRIG_PRESENT;
            n.en[ch]   = to_flags(HWDATA_I[7:0]);
         end else if (in_ch && off == tcs_pkg::OFF_STATUS) begin
            clr_req[ch] = ~to_flags(HWDATA_I[7:0]);
         end else if (in_ch && off == tcs_pkg::OFF_CLEAR) begin
            clr_req[ch] = to_flags(HWDATA_I[7:0]);
         end else if (in_ch && off == tcs_pkg::OFF_COUNTER) begin
            wr_cnt[ch] = 1'b1;
         end else if (in_ch && off == tcs_pkg::OFF_GEN_A) begin
            wr_greg[ch] = 1'b1;
         end else if (r.addr == tcs_pkg::OFF_CONTROL) begin
            n.start = HWDATA_I[1:0];
         end
      end

      // read data phase: one wait state, then data from a flop
      if (r.rd_pend) begin
         if (in_ch && off == tcs_pkg::OFF_IO_CTRL) begin
            rd[3:0] = r.io[ch];
         end else if (in_ch && off == tcs_pkg::OFF_IRQ_EN) begin
            rd[7:0] = en_byte(r.conv_trigger_en[ch], r.en[ch]);
         end else if (in_ch && off == tcs_pkg::OFF_STATUS) begin
            rd[7:0] = st_byte(r.dir[ch], r.flag[ch]);
            arm[ch] = r.flag[ch];
         end else if (in_ch && off == tcs_pkg::OFF_COUNTER) begin
            rd[15:0] = r.cnt[ch];
         end else if (in_ch && off == tcs_pkg::OFF_GEN_A) begin
            rd[15:0] = r.greg[ch];
         end else if (r.addr == tcs_pkg::OFF_CONTROL) begin
            rd[1:0] = r.start;
         end
         n.rdata = rd;
         n.ready = 1'b1;
      end

      // address phase
      n.wr_pend = 1'b0;
      n.rd_pend = 1'b0;
      if (accept) begin
         n.addr    = {HADDR_I[6:2], 2'b00};
         n.wr_pend = HWRITE_I;
         n.rd_pend = ~HWRITE_I;
         n.ready   = HWRITE_I;
      end

      // counters, capture loads and event flags per channel
      for (int i = 0; i < 2; i++) begin
         if (wr_cnt[i]) begin
            n.cnt[i] = HWDATA_I[15:0];
         end else if (COUNT_TICK_I[i] && r.start[i]) begin
            n.step[i] = 1'b1;
            n.dir[i]  = ~COUNT_DOWN_I[i];
            if (COUNT_DOWN_I[i]) begin
               n.cnt[i] = r.cnt[i] - 16'h0001;
               setv[i][tcs_pkg::FLG_UNF] = (r.cnt[i] == tcs_pkg::CNT_BOTTOM);
            end else begin
               n.cnt[i] = r.cnt[i] + 16'h0001;
               setv[i][tcs_pkg::FLG_OVF] = (r.cnt[i] == tcs_pkg::CNT_TOP);
            end
         end
         if (wr_greg[i]) begin
            n.greg[i] = HWDATA_I[15:0];
         end else if (pin_cap[i]) begin
            n.greg[i] = r.cnt[i];
         end
         setv[i][tcs_pkg::FLG_A] = pin_cap[i] | pin_match[i];
         setv[i][tcs_pkg::FLG_B] = GEN_B_EVENT_I[i];
         n.conv[i] = r.conv_trigger_en[i] & (pin_cap[i] | pin_match[i]);
         // clear only flags seen as one by a read; a new event beats the clear
         n.flag[i]  = (r.flag[i] & ~(clr_req[i] & r.armed[i])) | setv[i];
         n.armed[i] = (r.armed[i] & ~clr_req[i]) | arm[i];
         n.irq[i]   = n.flag[i] & n.en[i];
      end
      n.any_irq = |n.irq;
   end

   // state register
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         r        <= '0;
         r.ready  <= 1'b1;
         r.resp   <= tcs_pkg::HRESP_OKAY;
         r.io     <= {2{tcs_pkg::RST_IO}};
         r.dir    <= {2{tcs_pkg::RST_DIR}};
         r.cnt    <= {2{tcs_pkg::RST_COUNTER}};
         r.greg   <= {2{tcs_pkg::RST_GEN_A}};
      end else begin
         r <= n;
      end
   end

   // outputs straight from flops
   assign HRDATA_O    = r.rdata;
   assign HREADYOUT_O = r.ready;
   assign HRESP_O     = r.resp;
   assign A_PIN_O     = pin_lvl;
   assign A_PIN_OE_O  = pin_oe;
   assign IRQ_GEN_A_O = {r.irq[1][tcs_pkg::FLG_A], r.irq[0][tcs_pkg::FLG_A]};
   assign IRQ_GEN_B_O = {r.irq[1][tcs_pkg::FLG_B], r.irq[0][tcs_pkg::FLG_B]};
   assign IRQ_OVF_O   = {r.irq[1][tcs_pkg::FLG_OVF], r.irq[0][tcs_pkg::FLG_OVF]};
   assign IRQ_UNF_O   = {r.irq[1][tcs_pkg::FLG_UNF], r.irq[0][tcs_pkg::FLG_UNF]};
   assign IRQ_O       = r.any_irq;
   assign CONV_REQ_O  = r.conv;
endmodule
`default_nettype wire

// *** verification/tcs_core_sva.sv ***
// bus, interrupt and trigger checks on the timer channel core ports
`timescale 1ns/1ps
`default_nettype none
module tcs_core_sva (
   input wire logic        CLK_SYS_I,
   input wire logic        RESETN_I,
   input wire logic        HSEL_I,
   input wire logic [1:0]  HTRANS_I,
   input wire logic        HWRITE_I,
   input wire logic [2:0]  HSIZE_I,
   input wire logic        HREADY_I,
   input wire logic [31:0] HRDATA_O,
   input wire logic        HREADYOUT_O,
   input wire logic        HRESP_O,
   input wire logic [1:0]  IRQ_GEN_A_O,
   input wire logic [1:0]  IRQ_GEN_B_O,
   input wire logic [1:0]  IRQ_OVF_O,
   input wire logic [1:0]  IRQ_UNF_O,
   input wire logic        IRQ_O,
   input wire logic [1:0]  CONV_REQ_O
);
   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (!RESETN_I);
   // transfer taken by the slave
   wire tk = HSEL_I & HREADY_I & (HTRANS_I == tcs_pkg::HTRANS_NONSEQ)
             & (HSIZE_I == tcs_pkg::HSIZE_WORD);
   wire rd_tk = tk & !HWRITE_I;
   wire any_line = |{IRQ_GEN_A_O, IRQ_GEN_B_O, IRQ_OVF_O, IRQ_UNF_O};
   logic rd_q;
   logic rd_qq;
   // read data may only move two edges after a read is taken
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rd_q  <= 1'b0;
         rd_qq <= 1'b0;
      end else begin
         rd_q  <= rd_tk;
         rd_qq <= rd_q;
      end
   end
   sequence s_wait_one;
      !HREADYOUT_O ##1 HREADYOUT_O;
   endsequence
   a_read_wait: assert property (rd_tk |=> s_wait_one)
      else $error("read did not wait exactly one cycle");
   a_write_nowait: assert property (tk && HWRITE_I |=> HREADYOUT_O)
      else $error("write inserted a wait");
   a_wait_short: assert property (!HREADYOUT_O |=> HREADYOUT_O)
      else $error("wait longer than one cycle");
   a_resp_okay: assert property (HRESP_O == tcs_pkg::HRESP_OKAY)
      else $error("response not okay");
   a_rdata_hold: assert property (!rd_qq |-> $stable(HRDATA_O))
      else $error("read data changed without a read");
   a_irq_follow: assert property (any_line |-> ##[0:1] IRQ_O)
      else $error("summary irq missing");
   a_irq_drop: assert property (!any_line [*2] |-> !IRQ_O)
      else $error("summary irq without a line");
   a_conv_pulse4: assert property (CONV_REQ_O[0] |=> !CONV_REQ_O[0])
      else $error("ch4 conversion request longer than a pulse");
   a_conv_pulse5: assert property (CONV_REQ_O[1] |=> !CONV_REQ_O[1])
      else $error("ch5 conversion request longer than a pulse");
endmodule
bind tcs_core tcs_core_sva i_tcs_core_sva (.CLK_SYS_I, .RESETN_I, .HSEL_I, .HTRANS_I,
   .HWRITE_I, .HSIZE_I, .HREADY_I, .HRDATA_O, .HREADYOUT_O, .HRESP_O, .IRQ_GEN_A_O,
   .IRQ_GEN_B_O, .IRQ_OVF_O, .IRQ_UNF_O, .IRQ_O, .CONV_REQ_O);
`default_nettype wire

// *** verification/tcs_core_tb.sv ***
// self-checking bench for the timer channel core
`timescale 1ns/1ps
`default_nettype none
module tcs_core_tb;
   localparam logic [6:0] C5  = tcs_pkg::CH_STRIDE;
   localparam logic [6:0] IO  = tcs_pkg::OFF_IO_CTRL;
   localparam logic [6:0] EN  = tcs_pkg::OFF_IRQ_EN;
   localparam logic [6:0] ST  = tcs_pkg::OFF_STATUS;
   localparam logic [6:0] CN  = tcs_pkg::OFF_COUNTER;
   localparam logic [6:0] GA  = tcs_pkg::OFF_GEN_A;
   localparam logic [6:0] CTL = tcs_pkg::OFF_CONTROL;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hready;
   logic [1:0]  tick = 2'h0;
   logic [1:0]  down = 2'h0;
   logic        ch3 = 1'b0;
   logic [1:0]  pin = 2'h0;
   logic [1:0]  gev = 2'h0;
   logic [1:0]  pin_o, pin_oe, i_a, i_b, i_v, i_u, conv;
   logic        irq;
   int          miscompares = 0;
   int          checks = 0;
   // 20 MHz system clock
   always #25 clk = ~clk;
   tcs_core i_tcs_core (.CLK_SYS_I(clk), .RESETN_I(resetn), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(tcs_pkg::HSIZE_WORD),
      .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
      .HRESP_O(), .COUNT_TICK_I(tick), .COUNT_DOWN_I(down), .GEN_B_EVENT_I(gev),
      .CH3_A_EVENT_I(ch3), .A_PIN_I(pin), .A_PIN_O(pin_o), .A_PIN_OE_O(pin_oe),
      .IRQ_GEN_A_O(i_a), .IRQ_GEN_B_O(i_b), .IRQ_OVF_O(i_v), .IRQ_UNF_O(i_u), .IRQ_O(irq),
      .CONV_REQ_O(conv));
   task automatic give_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // one word transfer; holds each phase until ready is sampled high
   task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      hsel   <= 1'b1;
      htrans <= tcs_pkg::HTRANS_NONSEQ;
      haddr  <= {25'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [6:0] a, input logic [31:0] exp, input string what);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(r, exp, what);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic step(input int ch);
      tick[ch] <= 1'b1;
      @(posedge clk);
      tick[ch] <= 1'b0;
      cyc(4);
   endtask
   // counts conversion pulses over a short window after an edge
   task automatic conv_cnt(input int ch, input logic [31:0] exp);
      logic [31:0] n;
      n = 32'h0;
      repeat (6) begin
         @(posedge clk);
         if (conv[ch] === 1'b1) n++;
      end
      chk(n, exp, "conversion pulses");
   endtask
   task automatic t_reset;
      rd(EN, 32'h40, "enable reset");
      rd(ST, 32'hc0, "status reset");
      rd(CN, 32'h0, "counter reset");
      rd(7'h7c, 32'h0, "unmapped read");
      $display("reset test done");
   endtask
   task automatic t_regs;
      wr(C5 + EN, 32'hff);
      rd(C5 + EN, 32'hf3, "enable mask");
      wr(ST, 32'hff);
      rd(ST, 32'hc0, "status ones write");
      $display("register test done");
   endtask
   task automatic t_ovf;
      wr(EN, 32'h10);
      wr(CN, 32'hffff);
      wr(CTL, 32'h1);
      step(0);
      chk(i_v[0], 32'h1, "overflow irq");
      chk(irq, 32'h1, "summary irq");
      wr(ST, 32'h0);
      rd(ST, 32'hd0, "clear without read");
      wr(ST, 32'h0);
      cyc(2);
      rd(ST, 32'hc0, "clear after read");
      chk(i_v[0], 32'h0, "overflow irq off");
      rd(CN, 32'h0, "up wrap");
      $display("overflow test done");
   endtask
   task automatic t_unf;
      down[0] <= 1'b1;
      wr(CN, 32'h0);
      wr(EN, 32'h20);
      step(0);
      rd(CN, 32'hffff, "down wrap");
      // wrap lands on the a register reset value, so a compare match sets flag a too
      rd(ST, 32'h61, "down status");
      chk(i_u[0], 32'h1, "underflow irq");
      wr(EN, 32'h0);
      cyc(2);
      chk(i_u[0], 32'h0, "underflow masked");
      // both flags were read as one above, so a zero write clears them
      wr(ST, 32'h0);
      rd(ST, 32'h40, "read then clear");
      down[0] <= 1'b0;
      $display("underflow test done");
   endtask
   task automatic t_cap;
      wr(EN, 32'h81);
      wr(CN, 32'h1234);
      wr(IO, 32'h8);
      pin[0] <= 1'b1;
      conv_cnt(0, 32'h1);
      rd(GA, 32'h1234, "rise capture");
      rd(ST, 32'h41, "capture flag");
      chk(i_a[0], 32'h1, "a irq");
      wr(C5 + EN, 32'h01);
      wr(C5 + CN, 32'h55);
      wr(C5 + IO, 32'hd);
      pin[1] <= 1'b1;
      conv_cnt(1, 32'h0);
      rd(C5 + ST, 32'hc0, "rise ignored");
      wr(C5 + CN, 32'h66);
      pin[1] <= 1'b0;
      cyc(4);
      rd(C5 + GA, 32'h66, "fall capture");
      wr(IO, 32'hc);
      wr(CN, 32'h777);
      ch3 <= 1'b1;
      @(posedge clk);
      ch3 <= 1'b0;
      cyc(4);
      rd(GA, 32'h777, "cascade capture");
      $display("capture test done");
   endtask
   task automatic t_cmp;
      wr(C5 + EN, 32'h0);
      wr(C5 + IO, 32'h2);
      cyc(2);
      chk(pin_oe[1], 32'h1, "pin driven");
      chk(pin_o[1], 32'h0, "initial low");
      wr(C5 + GA, 32'h10);
      wr(C5 + CN, 32'hf);
      wr(CTL, 32'h3);
      step(1);
      chk(pin_o[1], 32'h1, "set on match");
      wr(C5 + IO, 32'h7);
      wr(C5 + CN, 32'hf);
      cyc(2);
      chk(pin_o[1], 32'h1, "initial high");
      step(1);
      chk(pin_o[1], 32'h0, "toggle on match");
      wr(C5 + IO, 32'h4);
      cyc(2);
      chk(pin_oe[1], 32'h0, "pin off");
      $display("compare test done");
   endtask
   // b event pulse on channel 5 raises flag b and its request line
   task automatic t_genb;
      wr(C5 + EN, 32'h02);
      gev[1] <= 1'b1;
      @(posedge clk);
      gev[1] <= 1'b0;
      cyc(3);
      chk(i_b[1], 32'h1, "b irq");
      rd(C5 + ST, 32'hc3, "b flag");
      wr(C5 + EN, 32'h0);
      cyc(2);
      chk(i_b[1], 32'h0, "b irq masked");
      $display("b event test done");
   endtask
   // main sequence: reset held 10 cycles, then every scenario
   initial begin
      cyc(10);
      resetn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_regs();
      t_ovf();
      t_unf();
      t_cap();
      t_cmp();
      t_genb();
      give_verdict();
   end
   // watchdog, well beyond the few hundred cycles the tests take
   initial begin
      cyc(3000);
      miscompares++;
      $display("ERROR %0t watchdog expired", $time);
      give_verdict();
   end
endmodule
`default_nettype wire
